// ---- mtci_pkg.sv ----
`default_nettype none
package mtci_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int NCH = 5;
    localparam int NSRC = 3;
    localparam int SRC_CMP = 0;
    localparam int SRC_OVF = 1;
    localparam int SRC_UNF = 2;
    localparam int CASC_UP = 1;
    localparam int CASC_LO = 2;
    localparam int PWM2_CH_MAX = 2;
    localparam logic [4:0] PHASE_OK = 5'h16;
    localparam int PSC_W = 6;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] A_START = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQEN = 8'h08;
    localparam logic [7:0] A_PINIO = 8'h0c;
    localparam logic [7:0] A_CASC = 8'h60;
    localparam logic [7:0] A_PRIO = 8'h64;
    localparam logic [3:0] CH_FIRST = 4'h1;
    localparam logic [3:0] CH_LAST = 4'h5;
    localparam logic [1:0] R_MODE = 2'h0;
    localparam logic [1:0] R_CNT = 2'h1;
    localparam logic [1:0] R_CMPA = 2'h2;
    localparam logic [1:0] R_CMPB = 2'h3;
    localparam int PINIO_W = 4;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CMP_RST = 16'hffff;
    localparam logic [2:0] PSC_CASCADE = 3'h7;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        MD_NORMAL = 2'b00,
        MD_PWM1 = 2'b01,
        MD_PWM2 = 2'b10,
        MD_PHASE = 2'b11
    } mtci_opmode_t;
    typedef struct packed {
        logic [2:0] prescale;
        mtci_opmode_t opmode;
    } mtci_mode_t;
    typedef struct packed {
        logic unf;
        logic ovf;
        logic cmp;
    } mtci_evt_t;
    localparam mtci_mode_t MODE_RST = '{prescale: 3'h0, opmode: MD_NORMAL};
endpackage
`default_nettype wire

// ---- mtci_top.sv ----
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - cascade reads channel 1 as upper and channel 2 as lower half of 32 bits
// - cascade prescale code makes channel 1 count on channel 2 wraps
// - lower counter underflows only in phase mode; otherwise it only overflows
// - phase mode on channel 1, 2 or 4 ignores the clock select
// - three sources per channel: compare, overflow, underflow, each flag and enable
// - event sets its flag; request raised only when its enable is one
// - request held until software clears the flag or its enable
// - fixed source priority inside a channel; channel priority left outside
// - pwm mode 1 pin init leaves the b-side compare pin untouched
// - pwm mode 2 pin init leaves the cycle register pin untouched
// - pwm mode 2 only accepted on channels 0 to 2
module mtci_top #(
    parameter int NCH = mtci_pkg::NCH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [NCH-1:0] phase_a_in,
    input wire logic [NCH-1:0] phase_b_in,
    output logic [NCH-1:0] pin_a_out,
    output logic [NCH-1:0] pin_a_oe,
    output logic [NCH-1:0] compare_pin_b_side,
    output logic [NCH-1:0] pin_b_oe,
    output logic irq
);
    // ************************************************************
    // state
    // ************************************************************
    localparam int SW = NCH * mtci_pkg::NSRC;
    logic [NCH-1:0] counter_start_control_r;
    logic [SW-1:0] timer_status_flags_r;
    logic [SW-1:0] timer_irq_enable_r;
    logic [NCH*mtci_pkg::PINIO_W-1:0] pin_io_control_r;
    mtci_pkg::mtci_mode_t channel_mode_register_r [NCH];
    logic [NCH-1:0][15:0] channel_counter_r;
    logic [NCH-1:0][15:0] cmpa_r;
    logic [NCH-1:0][15:0] cmpb_r;
    logic [mtci_pkg::PSC_W-1:0] psc_r;
    logic [NCH-1:0] pha_s1_r, pha_s2_r, pha_d_r;
    logic [NCH-1:0] phb_s1_r, phb_s2_r, phb_d_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    // ************************************************************
    // apb decode
    // ************************************************************
    logic wr_en;
    logic setup;
    logic ch_hit;
    logic [3:0] ch_idx;
    logic [1:0] ch_reg;
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign ch_hit = (paddr[7:4] >= mtci_pkg::CH_FIRST) &&
                    (paddr[7:4] <= mtci_pkg::CH_LAST) && (paddr[1:0] == 2'h0);
    assign ch_idx = paddr[7:4] - mtci_pkg::CH_FIRST;
    assign ch_reg = paddr[3:2];
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    function automatic logic ch_wr(input int i, input logic [1:0] r);
        return wr_en && ch_hit && (ch_idx == 4'(i)) && (ch_reg == r);
    endfunction
    // ************************************************************
    // prescaler
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_r <= '0;
        end else begin
            psc_r <= psc_r + 6'h01;
        end
    end
    function automatic logic psc_tick(input logic [2:0] sel,
                                      input logic [5:0] p);
        case (sel)
            3'h0: return 1'b1;
            3'h1: return &p[1:0];
            3'h2: return &p[3:0];
            3'h3: return &p[5:0];
            default: return 1'b0;
        endcase
    endfunction
    // ************************************************************
    // phase inputs: two-flop sync, then edge history
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pha_s1_r <= '0;
            pha_s2_r <= '0;
            pha_d_r <= '0;
            phb_s1_r <= '0;
            phb_s2_r <= '0;
            phb_d_r <= '0;
        end else begin
            pha_s1_r <= phase_a_in;
            pha_s2_r <= pha_s1_r;
            pha_d_r <= pha_s2_r;
            phb_s1_r <= phase_b_in;
            phb_s2_r <= phb_s1_r;
            phb_d_r <= phb_s2_r;
        end
    end
    // ************************************************************
    // per-channel count control
    // ************************************************************
    logic [NCH-1:0] tick, down, run, clr, ma, mb;
    mtci_pkg::mtci_evt_t [NCH-1:0] evt;
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        mtci_pkg::mtci_mode_t m;
        logic phase;
        assign m = channel_mode_register_r[i];
        assign phase = (m.opmode == mtci_pkg::MD_PHASE);
        assign run[i] = counter_start_control_r[i];
        always_comb begin
            if (phase) begin
                // clock select is ignored in phase mode
                tick[i] = (pha_s2_r[i] ^ pha_d_r[i]) | (phb_s2_r[i] ^ phb_d_r[i]);
                down[i] = ~(pha_s2_r[i] ^ phb_d_r[i]);
            end else if (i == mtci_pkg::CASC_UP && m.prescale == mtci_pkg::PSC_CASCADE) begin
                tick[i] = evt[mtci_pkg::CASC_LO].ovf | evt[mtci_pkg::CASC_LO].unf;
                down[i] = evt[mtci_pkg::CASC_LO].unf;
            end else begin
                tick[i] = psc_tick(m.prescale, psc_r);
                down[i] = 1'b0;
            end
        end
        assign ma[i] = run[i] & tick[i] & (channel_counter_r[i] == cmpa_r[i]);
        assign mb[i] = run[i] & tick[i] & (channel_counter_r[i] == cmpb_r[i]);
        // the b register sets the period in both pwm modes
        assign clr[i] = mb[i] & (m.opmode inside {mtci_pkg::MD_PWM1, mtci_pkg::MD_PWM2});
        assign evt[i].cmp = ma[i] | mb[i];
        assign evt[i].ovf = run[i] & tick[i] & ~down[i] & ~clr[i] &
                            (channel_counter_r[i] == mtci_pkg::CNT_MAX);
        assign evt[i].unf = run[i] & tick[i] & down[i] &
                            (channel_counter_r[i] == 16'h0000);
    end
    // ************************************************************
    // counters
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_counter_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_wr(i, mtci_pkg::R_CNT)) begin
                    channel_counter_r[i] <= pwdata[15:0];
                end else if (run[i] && tick[i]) begin
                    if (clr[i]) begin
                        channel_counter_r[i] <= 16'h0000;
                    end else if (down[i]) begin
                        channel_counter_r[i] <= channel_counter_r[i] - 16'h0001;
                    end else begin
                        channel_counter_r[i] <= channel_counter_r[i] + 16'h0001;
                    end
                end
            end
        end
    end
    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                channel_mode_register_r[i] <= mtci_pkg::MODE_RST;
            end
            cmpa_r <= {NCH{mtci_pkg::CMP_RST}};
            cmpb_r <= {NCH{mtci_pkg::CMP_RST}};
            counter_start_control_r <= '0;
            timer_irq_enable_r <= '0;
            pin_io_control_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_wr(i, mtci_pkg::R_MODE)) begin
                    channel_mode_register_r[i].prescale <= pwdata[4:2];
                    channel_mode_register_r[i].opmode <= mtci_pkg::mtci_opmode_t'(pwdata[1:0]);
                    // unsupported modes fall back to normal
                    if ((pwdata[1:0] == mtci_pkg::MD_PWM2 && i > mtci_pkg::PWM2_CH_MAX) ||
                        (pwdata[1:0] == mtci_pkg::MD_PHASE && !mtci_pkg::PHASE_OK[i])) begin
                        channel_mode_register_r[i].opmode <= mtci_pkg::MD_NORMAL;
                    end
                end
                if (ch_wr(i, mtci_pkg::R_CMPA)) begin
                    cmpa_r[i] <= pwdata[15:0];
                end
                if (ch_wr(i, mtci_pkg::R_CMPB)) begin
                    cmpb_r[i] <= pwdata[15:0];
                end
            end
            if (wr_en && paddr == mtci_pkg::A_START) begin
                counter_start_control_r <= pwdata[NCH-1:0];
            end
            if (wr_en && paddr == mtci_pkg::A_IRQEN) begin
                timer_irq_enable_r <= pwdata[SW-1:0];
            end
            if (wr_en && paddr == mtci_pkg::A_PINIO) begin
                pin_io_control_r <= pwdata[NCH*mtci_pkg::PINIO_W-1:0];
            end
        end
    end
    // ************************************************************
    // compare pins
    // ************************************************************
    logic pinio_wr;
    assign pinio_wr = wr_en && (paddr == mtci_pkg::A_PINIO);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_out <= '0;
            compare_pin_b_side <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                unique case (channel_mode_register_r[i].opmode)
                    mtci_pkg::MD_PWM1: begin
                        if (pinio_wr) begin
                            pin_a_out[i] <= pwdata[i*mtci_pkg::PINIO_W];
                            // b-side pin keeps its level here
                        end else if (clr[i]) begin
                            pin_a_out[i] <= 1'b0;
                        end else if (ma[i]) begin
                            pin_a_out[i] <= 1'b1;
                        end
                    end
                    mtci_pkg::MD_PWM2: begin
                        if (pinio_wr) begin
                            pin_a_out[i] <= pwdata[i*mtci_pkg::PINIO_W];
                            // cycle register pin keeps its level
                        end else if (clr[i]) begin
                            pin_a_out[i] <= 1'b1;
                        end else if (ma[i]) begin
                            pin_a_out[i] <= 1'b0;
                        end
                    end
                    default: begin
                        if (pinio_wr) begin
                            pin_a_out[i] <= pwdata[i*mtci_pkg::PINIO_W];
                            compare_pin_b_side[i] <= pwdata[i*mtci_pkg::PINIO_W+1];
                        end else begin
                            pin_a_out[i] <= pin_a_out[i] ^ ma[i];
                            compare_pin_b_side[i] <= compare_pin_b_side[i] ^ mb[i];
                        end
                    end
                endcase
            end
        end
    end
    for (genvar i = 0; i < NCH; i++) begin : g_oe
        assign pin_a_oe[i] = pin_io_control_r[i*mtci_pkg::PINIO_W+2];
        assign pin_b_oe[i] = pin_io_control_r[i*mtci_pkg::PINIO_W+3];
    end
    // ************************************************************
    // interrupt flags
    // ************************************************************
    logic [SW-1:0] evt_flat, flag_clr, pend;
    assign evt_flat = evt;
    assign flag_clr = (wr_en && paddr == mtci_pkg::A_STATUS) ? pwdata[SW-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_status_flags_r <= '0;
        end else begin
            // a new event wins over a clear in the same cycle
            timer_status_flags_r <= (timer_status_flags_r & ~flag_clr) | evt_flat;
        end
    end
    assign pend = timer_status_flags_r & timer_irq_enable_r;
    assign irq = |pend;
    // per-channel winner: compare, then overflow, then underflow
    logic [2*NCH-1:0] prio;
    for (genvar i = 0; i < NCH; i++) begin : g_prio
        logic [2:0] p;
        assign p = pend[i*3 +: 3];
        assign prio[2*i +: 2] = p[0] ? 2'h1 : p[1] ? 2'h2 : p[2] ? 2'h3 : 2'h0;
    end
    // ************************************************************
    // read path, sampled in the setup cycle
    // ************************************************************
    logic [31:0] rd_data;
    logic rd_err;
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (ch_hit) begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_idx == 4'(i)) begin
                    unique case (ch_reg)
                        mtci_pkg::R_MODE: rd_data[4:0] = channel_mode_register_r[i];
                        mtci_pkg::R_CNT: rd_data[15:0] = channel_counter_r[i];
                        mtci_pkg::R_CMPA: rd_data[15:0] = cmpa_r[i];
                        mtci_pkg::R_CMPB: rd_data[15:0] = cmpb_r[i];
                    endcase
                end
            end
        end else begin
            unique case (paddr)
                mtci_pkg::A_START: rd_data[NCH-1:0] = counter_start_control_r;
                mtci_pkg::A_STATUS: rd_data[SW-1:0] = timer_status_flags_r;
                mtci_pkg::A_IRQEN: rd_data[SW-1:0] = timer_irq_enable_r;
                mtci_pkg::A_PINIO: rd_data[NCH*mtci_pkg::PINIO_W-1:0] = pin_io_control_r;
                mtci_pkg::A_CASC: rd_data = {channel_counter_r[mtci_pkg::CASC_UP],
                                             channel_counter_r[mtci_pkg::CASC_LO]};
                mtci_pkg::A_PRIO: rd_data[2*NCH-1:0] = prio;
                default: rd_err = 1'b1;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_r <= rd_err;
        end
    end
endmodule
`default_nettype wire

// ---- mtci_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module mtci_checker #(
    parameter int NCH = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [NCH-1:0] phase_a_in,
    input wire logic [NCH-1:0] phase_b_in,
    input wire logic [NCH-1:0] pin_a_out,
    input wire logic [NCH-1:0] pin_a_oe,
    input wire logic [NCH-1:0] compare_pin_b_side,
    input wire logic [NCH-1:0] pin_b_oe,
    input wire logic irq
);
    // ********
    // bus shadow
    // ********
    logic wr;
    logic mapped;
    logic [14:0] en_r;
    logic [NCH-1:0] pwm_r;
    logic [NCH-1:0] oea_r;
    logic [NCH-1:0] oeb_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr = psel && penable && pwrite && pready;
    assign mapped = (paddr <= mtci_pkg::A_PINIO) || (paddr == mtci_pkg::A_CASC)
        || (paddr == mtci_pkg::A_PRIO)
        || (paddr[7:4] >= mtci_pkg::CH_FIRST && paddr[7:4] <= mtci_pkg::CH_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= '0;
        end else if (wr && paddr == mtci_pkg::A_IRQEN) begin
            en_r <= pwdata[14:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oea_r <= '0;
            oeb_r <= '0;
        end else if (wr && paddr == mtci_pkg::A_PINIO) begin
            for (int i = 0; i < NCH; i++) begin
                oea_r[i] <= pwdata[4*i+2];
                oeb_r[i] <= pwdata[4*i+3];
            end
        end
    end
    // pwm2 on a channel above the limit is stored as normal, so it never counts here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_r <= '0;
        end else if (wr && paddr[3:0] == 4'h0) begin
            for (int i = 0; i < NCH; i++) begin
                if (paddr[7:4] == 4'(i + 1)) begin
                    pwm_r[i] <= (pwdata[1:0] == 2'b01)
                        || (pwdata[1:0] == 2'b10 && i <= mtci_pkg::PWM2_CH_MAX);
                end
            end
        end
    end
    // ********
    // assertions
    // ********
    a_ready_zero_wait: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
        else $error("pslverr does not match the address map");
    a_rdata_hold: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved after the access cycle");
    a_status_width: assert property (
        psel && penable && !pwrite && paddr == mtci_pkg::A_STATUS |-> prdata[31:15] == 17'h0)
        else $error("status reads bits above the fifteen sources");
    a_irq_enable: assert property (irq |-> en_r != 15'h0)
        else $error("irq high with no enable set");
    a_irq_masked: assert property (
        wr && paddr == mtci_pkg::A_IRQEN && pwdata[14:0] == 15'h0 |=> !irq [*2])
        else $error("irq high after all enables cleared");
    a_irq_hold: assert property (
        $fell(irq) |-> $past(wr && (paddr == mtci_pkg::A_STATUS || paddr == mtci_pkg::A_IRQEN)))
        else $error("irq dropped without a status or enable write");
    a_pwm_pin_b: assert property (
        (pwm_r & $past(pwm_r) & (compare_pin_b_side ^ $past(compare_pin_b_side))) == '0)
        else $error("b-side pin moved in a pwm mode");
    a_oe_follow: assert property (pin_a_oe == oea_r && pin_b_oe == oeb_r)
        else $error("pin enables differ from the last pin control write");
    c_irq_rise: cover property ($rose(irq));
    c_err_seen: cover property (psel && penable && pslverr);
    c_pwm_init: cover property (wr && paddr == mtci_pkg::A_PINIO && (|pwm_r));
endmodule
bind mtci_top mtci_checker #(.NCH(NCH)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .phase_a_in(phase_a_in), .phase_b_in(phase_b_in),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .compare_pin_b_side(compare_pin_b_side),
    .pin_b_oe(pin_b_oe), .irq(irq));
`default_nettype wire

// ---- mtci_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module mtci_tb_top;
    localparam int NCH = mtci_pkg::NCH;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, irq;
    logic [31:0] prdata, rdat, c1, c2;
    logic [NCH-1:0] pha = '0;
    logic [NCH-1:0] phb = '0;
    logic [NCH-1:0] pao, paoe, pbo, pboe;
    logic rerr;
    logic [1:0] seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    int num_errors = 0;
    int check_count = 0;
    int n, stat_m;
    mtci_top #(.NCH(NCH)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .phase_a_in(pha), .phase_b_in(phb), .pin_a_out(pao),
        .pin_a_oe(paoe), .compare_pin_b_side(pbo), .pin_b_oe(pboe), .irq(irq));
    initial begin
        forever #5 pclk = ~pclk;
    end
    // ********
    // bus tasks
    // ********
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // outputs are looked at one step after the edge so its updates have landed
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask
    function automatic logic [7:0] ra(input int ch, input logic [1:0] r);
        return 8'h10 + 8'(ch * 16) + {4'h0, r, 2'b00};
    endfunction
    task automatic finish_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
    // ********
    // main sequence
    // ********
    initial begin
        void'($urandom(38));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < NCH; c++) begin
            rd(ra(c, mtci_pkg::R_MODE));
            `CHK(rdat, 32'h0000_0000)
            rd(ra(c, mtci_pkg::R_CMPB));
            `CHK(rdat, 32'h0000_ffff)
        end
        rd(8'h70);
        `CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
        // cascade upward: lower counter starts just below its wrap
        wrt(ra(2, mtci_pkg::R_CNT), 32'h0000_fff0);
        wrt(ra(1, mtci_pkg::R_CNT), 32'h0000_1234);
        wrt(ra(1, mtci_pkg::R_MODE), 32'h0000_001c);
        // channel 0 on a reserved prescale code, channel 3 on the divide-by-four tap
        wrt(ra(0, mtci_pkg::R_MODE), 32'h0000_0014);
        wrt(ra(3, mtci_pkg::R_MODE), 32'h0000_0004);
        wrt(mtci_pkg::A_START, 32'h0000_000f);
        repeat (40) @(posedge pclk);
        wrt(mtci_pkg::A_START, 32'h0000_0000);
        rd(ra(2, mtci_pkg::R_CNT));
        c2 = rdat;
        rd(ra(1, mtci_pkg::R_CNT));
        c1 = rdat;
        `CHK(c2[15:0] < 16'h0100, 1'b1)
        `CHK(c1, 32'h0000_1235)
        rd(ra(0, mtci_pkg::R_CNT));
        `CHK(rdat, 32'h0000_0000)
        rd(ra(3, mtci_pkg::R_CNT));
        `CHK(rdat >= 32'd10 && rdat <= 32'd11, 1'b1)
        rd(mtci_pkg::A_CASC);
        `CHK(rdat, {c1[15:0], c2[15:0]})
        stat_m = 32'h0000_00c0;
        rd(mtci_pkg::A_STATUS);
        `CHK(rdat, 32'(stat_m))
        // cascade downward: lower counter in phase mode, driven through quadrature steps
        n = 3 + ($urandom % 6);
        wrt(ra(2, mtci_pkg::R_MODE), 32'h0000_0003);
        wrt(ra(2, mtci_pkg::R_CNT), 32'h0000_0002);
        wrt(ra(1, mtci_pkg::R_CNT), 32'h0000_0010);
        wrt(mtci_pkg::A_START, 32'h0000_0006);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            pha[2] <= seq[i % 4][1];
            phb[2] <= seq[i % 4][0];
            repeat (6) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        wrt(mtci_pkg::A_START, 32'h0000_0000);
        rd(ra(2, mtci_pkg::R_CNT));
        `CHK(rdat, {16'h0000, 16'(2 - n)})
        rd(ra(1, mtci_pkg::R_CNT));
        `CHK(rdat, 32'h0000_000f)
        stat_m = stat_m | 32'h0000_0100;
        rd(mtci_pkg::A_STATUS);
        `CHK(rdat, 32'(stat_m))
        // interrupt enable, priority and clearing
        tick();
        `CHK(irq, 1'b0)
        wrt(mtci_pkg::A_IRQEN, 32'h0000_0080);
        tick();
        `CHK(irq, 1'b1)
        rd(mtci_pkg::A_PRIO);
        `CHK(rdat, 32'h0000_0020)
        wrt(mtci_pkg::A_IRQEN, 32'h0000_01c0);
        rd(mtci_pkg::A_PRIO);
        `CHK(rdat, 32'h0000_0010)
        wrt(mtci_pkg::A_STATUS, 32'h0000_0040);
        stat_m = stat_m & ~32'h0000_0040;
        rd(mtci_pkg::A_STATUS);
        `CHK(rdat, 32'(stat_m))
        rd(mtci_pkg::A_PRIO);
        `CHK({irq, rdat}, {1'b1, 32'h0000_0020})
        wrt(mtci_pkg::A_STATUS, 32'h0000_0180);
        tick();
        `CHK(irq, 1'b0)
        wrt(mtci_pkg::A_IRQEN, 32'h0000_0000);
        // pwm2 is kept only on the low channels
        for (int c = 0; c < NCH; c++) begin
            wrt(ra(c, mtci_pkg::R_MODE), 32'h0000_0002);
            rd(ra(c, mtci_pkg::R_MODE));
            `CHK(rdat, (c <= mtci_pkg::PWM2_CH_MAX) ? 32'h0000_0002 : 32'h0000_0000)
            wrt(ra(c, mtci_pkg::R_MODE), 32'h0000_0003);
            rd(ra(c, mtci_pkg::R_MODE));
            `CHK(rdat, mtci_pkg::PHASE_OK[c] ? 32'h0000_0003 : 32'h0000_0000)
            wrt(ra(c, mtci_pkg::R_MODE), 32'h0000_0000);
        end
        // pin init: b side set in normal mode, then kept in pwm1 and pwm2
        wrt(mtci_pkg::A_PINIO, 32'h0000_00ff);
        tick();
        `CHK({pao[1:0], pbo[1:0], paoe, pboe}, {4'hf, 5'h03, 5'h03})
        wrt(ra(0, mtci_pkg::R_MODE), 32'h0000_0001);
        wrt(ra(1, mtci_pkg::R_MODE), 32'h0000_0002);
        wrt(mtci_pkg::A_PINIO, 32'h0000_00cc);
        tick();
        `CHK({pao[1:0], pbo[1:0]}, 4'h3)
        // short period on channel 0 so b matches occur while the b pin must hold
        wrt(ra(0, mtci_pkg::R_CMPB), 32'h0000_0009);
        wrt(mtci_pkg::A_START, 32'h0000_0003);
        repeat (30) @(posedge pclk);
        wrt(mtci_pkg::A_START, 32'h0000_0000);
        `CHK(pbo[1:0], 2'b11)
        rd(ra(0, mtci_pkg::R_CNT));
        `CHK(rdat <= 32'd9, 1'b1)
        // compare registers take random values
        for (int c = 0; c < NCH; c++) begin
            c1 = {16'h0000, 16'($urandom)};
            wrt(ra(c, mtci_pkg::R_CMPA), c1);
            rd(ra(c, mtci_pkg::R_CMPA));
            `CHK(rdat, c1)
        end
        finish_test();
    end
endmodule
`default_nettype wire
